// ===== core/cxpcfg_pkg.sv
// register map, field widths and encodings of the link config/status bank
// assumes a 32-bit Avalon-MM slave with byte addresses, one word per register
package cxpcfg_pkg;
  localparam int unsigned CXPCFG_AW = 8;
  // byte offsets
  localparam logic [7:0] OFS_SPEED       = 8'h00;
  localparam logic [7:0] OFS_SPEED_MAX   = 8'h04;
  localparam logic [7:0] OFS_LANES       = 8'h08;
  localparam logic [7:0] OFS_LANES_MAX   = 8'h0C;
  localparam logic [7:0] OFS_PAT_MODE    = 8'h10;
  localparam logic [7:0] OFS_PAT_LEVEL   = 8'h14;
  localparam logic [7:0] OFS_PROF_SEL    = 8'h18;
  localparam logic [7:0] OFS_PROF_LOAD   = 8'h1C;
  localparam logic [7:0] OFS_PROF_SAVE   = 8'h20;
  localparam logic [7:0] OFS_PROF_BOOT   = 8'h24;
  localparam logic [7:0] OFS_PROF_ACT    = 8'h28;
  localparam logic [7:0] OFS_ACQ         = 8'h2C;
  localparam logic [7:0] OFS_FROZEN      = 8'h30;
  localparam logic [7:0] OFS_LANE_SEL    = 8'h34;
  localparam logic [7:0] OFS_TEST_TX     = 8'h38;
  localparam logic [7:0] OFS_LAST_ERR    = 8'h3C;
  localparam logic [7:0] OFS_KCODE_ERR   = 8'h40;
  localparam logic [7:0] OFS_DISP_ERR    = 8'h44;
  localparam logic [7:0] OFS_PROTO_ERR   = 8'h48;
  localparam logic [7:0] OFS_H_SIZE      = 8'h4C;
  localparam logic [7:0] OFS_H_OFFSET    = 8'h50;
  localparam logic [7:0] OFS_V_SIZE      = 8'h54;
  localparam logic [7:0] OFS_V_OFFSET    = 8'h58;
  localparam logic [7:0] OFS_PIX_FMT     = 8'h5C;
  localparam logic [7:0] OFS_RESTART     = 8'h60;
  // encodings
  localparam logic [2:0]  SPEED_MIN      = 3'h2;
  localparam logic [2:0]  SPEED_MAX_DEF  = 3'h4;
  localparam logic [0:0]  LANES_MAX_DEF  = 1'h1;
  localparam logic [1:0]  PAT_OFF        = 2'h0;
  localparam logic [11:0] PAT_LEVEL_MAX  = 12'hFFF;
  localparam logic [1:0]  PROF_DEFAULT   = 2'h0;
  localparam logic [1:0]  PROF_LAST      = 2'h2;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_WORD  = 32'h0000_0000;
endpackage : cxpcfg_pkg

// ===== core/cxpcfg_bank.sv
// configuration and status register bank of the coaxial camera link
// assumes one 20 MHz clock; status/event inputs come from the same domain
// except acquisition/grab levels, which are synchronised here
//
// Summary of operation
// - count test packets on each lane; read back the lane picked by lane_select
// - hold last low-speed link protocol error code, read only
// - count 8b10b control-character errors; host write of zero clears
// - count running-disparity errors; host write of zero clears
// - count link protocol errors; host write of zero clears
// - read-only image size, offset and pixel format
// - speed grade 2/3/4; link takes the boot profile's grade, only at reset or restart
// - lane count 0 one lane, 1 two lanes; link takes the boot profile's count at restart
// - read-only max speed grade bounds the speed setting
// - read-only max lane count bounds the lane setting
// - pattern generator: off plus three pattern modes
// - pattern brightness 0 to 4095
// - profile select 0 default, 1 and 2 user sets
// - load command copies selected set into active settings
// - save command stores active settings under selected set 1 or 2; set 0 is protected
// - every reset clears boot select and user sets, then loads factory set 0
// - report loaded profile, updated by load and restart
// - acquisition status reads 1 while streaming
// - frozen flag reads 1 while grabbing
// - lane_select ranges 0 to max lane count
`timescale 1ns/1ps
`default_nettype none
module cxpcfg_bank
  import cxpcfg_pkg::*;
#(
  parameter int unsigned CNT_W = 32,
  parameter logic [2:0]  SPEED_MAX_P = SPEED_MAX_DEF,
  parameter logic [0:0]  LANES_MAX_P = LANES_MAX_DEF
)(
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_n,
  input  wire logic [CXPCFG_AW-1:0] i_avs_address,
  input  wire logic                i_avs_read,
  input  wire logic                i_avs_write,
  input  wire logic [31:0]         i_avs_writedata,
  input  wire logic [3:0]          i_avs_byteenable,
  output logic [31:0]              o_avs_readdata,
  output logic                     o_avs_waitrequest,
  input  wire logic [1:0]          i_test_tx_pulse,
  input  wire logic                i_kcode_err,
  input  wire logic                i_disp_err,
  input  wire logic                i_proto_err,
  input  wire logic [7:0]          i_proto_err_code,
  input  wire logic [15:0]         i_h_size,
  input  wire logic [15:0]         i_h_offset,
  input  wire logic [15:0]         i_v_size,
  input  wire logic [15:0]         i_v_offset,
  input  wire logic [15:0]         i_pix_fmt,
  input  wire logic                i_streaming,
  input  wire logic                i_grabbing,
  output logic [2:0]               o_speed_active,
  output logic                     o_lanes_active,
  output logic [1:0]               o_pat_mode,
  output logic [11:0]              o_pat_level,
  output logic                     o_save_req,
  output logic [1:0]               o_save_slot,
  output logic                     o_restart
);

  // stored user sets: speed, lanes, pattern mode, pattern level
  typedef struct packed {
    logic [2:0]  speed;
    logic        lanes;
    logic [1:0]  mode;
    logic [11:0] level;
  } cxpcfg_set_t;

  typedef enum logic [1:0] {
    CXPCFG_IDLE,
    CXPCFG_ACK
  } cxpcfg_bus_t;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  function automatic logic [31:0] zx16(input logic [15:0] v);
    zx16 = {16'h0000, v};
  endfunction : zx16

  cxpcfg_bus_t      bus_st;
  cxpcfg_set_t      nv_set [0:2];
  logic [2:0]       speed_cfg;
  logic             lanes_cfg;
  logic [1:0]       pat_mode;
  logic [11:0]      pat_level;
  logic [1:0]       prof_sel;
  logic [1:0]       prof_boot;
  logic [2:0]       prof_active;
  logic             lane_sel;
  logic [CNT_W-1:0] test_tx_cnt [0:1];
  logic [7:0]       last_err;
  logic [CNT_W-1:0] kcode_cnt;
  logic [CNT_W-1:0] disp_cnt;
  logic [CNT_W-1:0] proto_cnt;
  logic [1:0]       strm_sync;
  logic [1:0]       grab_sync;
  logic             boot_pend;
  logic             wr_go;
  logic             rd_go;
  logic             wr_zero;
  logic [31:0]      wd;
  logic [31:0]      next_rdata;
  cxpcfg_set_t      cur_set;

  // one wait cycle gives the read mux a registered output
  assign wr_go   = (bus_st == CXPCFG_ACK) && i_avs_write;
  assign rd_go   = (bus_st == CXPCFG_ACK) && i_avs_read;
  assign wd      = i_avs_writedata;
  assign wr_zero = (wd == ZERO_WORD) && (&i_avs_byteenable);
  assign cur_set = '{speed: speed_cfg, lanes: lanes_cfg,
                     mode: pat_mode, level: pat_level};

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bus_st            <= CXPCFG_IDLE;
      o_avs_waitrequest <= 1'b1;
    end
    else
    begin
      case (bus_st)
        CXPCFG_IDLE:
        begin
          if ((i_avs_read || i_avs_write) && !boot_pend)
          begin
            bus_st            <= CXPCFG_ACK;
            o_avs_waitrequest <= 1'b0;
          end
        end
        CXPCFG_ACK:
        begin
          bus_st            <= CXPCFG_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
        default:
        begin
          bus_st            <= CXPCFG_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_comb
  begin
    next_rdata = UNMAPPED_WORD;
    case (i_avs_address)
      OFS_SPEED:     next_rdata = {29'h0, speed_cfg};
      OFS_SPEED_MAX: next_rdata = {29'h0, SPEED_MAX_P};
      OFS_LANES:     next_rdata = {31'h0, lanes_cfg};
      OFS_LANES_MAX: next_rdata = {31'h0, LANES_MAX_P};
      OFS_PAT_MODE:  next_rdata = {30'h0, pat_mode};
      OFS_PAT_LEVEL: next_rdata = {20'h0, pat_level};
      OFS_PROF_SEL:  next_rdata = {30'h0, prof_sel};
      OFS_PROF_BOOT: next_rdata = {30'h0, prof_boot};
      OFS_PROF_ACT:  next_rdata = {29'h0, prof_active};
      OFS_ACQ:       next_rdata = {31'h0, strm_sync[1]};
      OFS_FROZEN:    next_rdata = {31'h0, grab_sync[1]};
      OFS_LANE_SEL:  next_rdata = {31'h0, lane_sel};
      OFS_TEST_TX:   next_rdata = 32'(test_tx_cnt[lane_sel]);
      OFS_LAST_ERR:  next_rdata = {24'h0, last_err};
      OFS_KCODE_ERR: next_rdata = 32'(kcode_cnt);
      OFS_DISP_ERR:  next_rdata = 32'(disp_cnt);
      OFS_PROTO_ERR: next_rdata = 32'(proto_cnt);
      OFS_H_SIZE:    next_rdata = zx16(i_h_size);
      OFS_H_OFFSET:  next_rdata = zx16(i_h_offset);
      OFS_V_SIZE:    next_rdata = zx16(i_v_size);
      OFS_V_OFFSET:  next_rdata = zx16(i_v_offset);
      OFS_PIX_FMT:   next_rdata = zx16(i_pix_fmt);
      default:       next_rdata = UNMAPPED_WORD;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_avs_readdata <= ZERO_WORD;
    else if ((bus_st == CXPCFG_IDLE) && i_avs_read)
      o_avs_readdata <= next_rdata;
  end

  // status levels cross in from the acquisition domain
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      strm_sync <= 2'b00;
      grab_sync <= 2'b00;
    end
    else
    begin
      strm_sync <= {strm_sync[0], i_streaming};
      grab_sync <= {grab_sync[0], i_grabbing};
    end
  end

  // live settings; boot_pend applies the boot profile after reset
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      boot_pend   <= 1'b1;
      speed_cfg   <= SPEED_MIN;
      lanes_cfg   <= 1'b0;
      pat_mode    <= PAT_OFF;
      pat_level   <= 12'h000;
      prof_active <= 3'h0;
    end
    else if (boot_pend || o_restart)
    begin
      boot_pend   <= 1'b0;
      speed_cfg   <= nv_set[prof_boot].speed;
      lanes_cfg   <= nv_set[prof_boot].lanes;
      pat_mode    <= nv_set[prof_boot].mode;
      pat_level   <= nv_set[prof_boot].level;
      prof_active <= {1'b0, prof_boot};
    end
    else if (wr_go && i_avs_address == OFS_PROF_LOAD)
    begin
      speed_cfg   <= nv_set[prof_sel].speed;
      lanes_cfg   <= nv_set[prof_sel].lanes;
      pat_mode    <= nv_set[prof_sel].mode;
      pat_level   <= nv_set[prof_sel].level;
      prof_active <= {1'b0, prof_sel};
    end
    else if (wr_go)
    begin
      case (i_avs_address)
        OFS_SPEED:
          if (wd[2:0] >= SPEED_MIN && wd[2:0] <= SPEED_MAX_P
              && wd[31:3] == 29'h0)
            speed_cfg <= wd[2:0];
        OFS_LANES:
          if (wd[0] <= LANES_MAX_P && wd[31:1] == 31'h0)
            lanes_cfg <= wd[0];
        OFS_PAT_MODE:
          pat_mode  <= wd[1:0];
        OFS_PAT_LEVEL:
          if (wd[11:0] <= PAT_LEVEL_MAX && wd[31:12] == 20'h0)
            pat_level <= wd[11:0];
        default:
          ;
      endcase
    end
  end

  // speed and lane count reach the link only after reset or at restart
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_speed_active <= SPEED_MIN;
      o_lanes_active <= 1'b0;
      o_pat_mode     <= PAT_OFF;
      o_pat_level    <= 12'h000;
    end
    else
    begin
      if (boot_pend || o_restart)
      begin
        o_speed_active <= nv_set[prof_boot].speed;
        o_lanes_active <= nv_set[prof_boot].lanes;
      end
      o_pat_mode  <= pat_mode;
      o_pat_level <= pat_level;
    end
  end

  // selectors and restart pulse
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      prof_sel  <= PROF_DEFAULT;
      prof_boot <= PROF_DEFAULT;
      lane_sel  <= 1'b0;
      o_restart <= 1'b0;
    end
    else
    begin
      o_restart <= wr_go && (i_avs_address == OFS_RESTART);
      if (wr_go && wd[31:2] == 30'h0 && wd[1:0] <= PROF_LAST)
      begin
        if (i_avs_address == OFS_PROF_SEL)
          prof_sel <= wd[1:0];
        if (i_avs_address == OFS_PROF_BOOT)
          prof_boot <= wd[1:0];
      end
      if (wr_go && i_avs_address == OFS_LANE_SEL
          && wd[31:1] == 31'h0 && wd[0] <= LANES_MAX_P)
        lane_sel <= wd[0];
    end
  end

  // non-volatile image kept in flops; slot 0 is the factory set
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < 3; i++)
        nv_set[i] <= '{speed: SPEED_MIN, lanes: 1'b0,
                       mode: PAT_OFF, level: 12'h000};
      o_save_req  <= 1'b0;
      o_save_slot <= PROF_DEFAULT;
    end
    else
    begin
      o_save_req <= 1'b0;
      // factory slot is write protected
      if (wr_go && i_avs_address == OFS_PROF_SAVE
          && prof_sel != PROF_DEFAULT)
      begin
        nv_set[prof_sel] <= cur_set;
        o_save_req       <= 1'b1;
        o_save_slot      <= prof_sel;
      end
    end
  end

  // test counters and error counters; events win over a clearing write
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      test_tx_cnt[0] <= '0;
      test_tx_cnt[1] <= '0;
      last_err       <= 8'h00;
      kcode_cnt      <= '0;
      disp_cnt       <= '0;
      proto_cnt      <= '0;
    end
    else
    begin
      for (int l = 0; l < 2; l++)
        if (i_test_tx_pulse[l])
          test_tx_cnt[l] <= test_tx_cnt[l] + 1'b1;
      if (i_proto_err)
        last_err <= i_proto_err_code;
      if (i_kcode_err)
        kcode_cnt <= sat_inc(kcode_cnt);
      else if (wr_go && i_avs_address == OFS_KCODE_ERR && wr_zero)
        kcode_cnt <= '0;
      if (i_disp_err)
        disp_cnt <= sat_inc(disp_cnt);
      else if (wr_go && i_avs_address == OFS_DISP_ERR && wr_zero)
        disp_cnt <= '0;
      if (i_proto_err)
        proto_cnt <= sat_inc(proto_cnt);
      else if (wr_go && i_avs_address == OFS_PROTO_ERR && wr_zero)
        proto_cnt <= '0;
    end
  end

  sequence s_load_wr;
    wr_go && i_avs_address == OFS_PROF_LOAD && !o_restart && !boot_pend;
  endsequence

  a_kcode_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_go && i_avs_address == OFS_KCODE_ERR && wr_zero && !i_kcode_err
    |=> kcode_cnt == '0) else $error("kcode count not cleared");
  a_disp_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_go && i_avs_address == OFS_DISP_ERR && wr_zero && !i_disp_err
    |=> disp_cnt == '0) else $error("disparity count not cleared");
  a_proto_count: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_proto_err && !(&proto_cnt) |=> proto_cnt == $past(proto_cnt) + 1'b1)
    else $error("protocol count missed");
  a_err_saturate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    &kcode_cnt && !wr_go |=> &kcode_cnt) else $error("counter wrapped");
  a_nonzero_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_go && i_avs_address == OFS_DISP_ERR && !wr_zero && !i_disp_err
    |=> $stable(disp_cnt)) else $error("nonzero write changed counter");
  a_speed_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !boot_pend && !o_restart |=> $stable(o_speed_active))
    else $error("speed changed without restart");
  a_speed_range: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !boot_pend |-> speed_cfg >= SPEED_MIN && speed_cfg <= SPEED_MAX_P)
    else $error("speed setting out of range");
  a_load_active: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_load_wr |=> prof_active == {1'b0, $past(prof_sel)}
    && pat_level == $past(nv_set[prof_sel].level))
    else $error("load did not apply profile");
  a_boot_apply: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    boot_pend |=> !boot_pend && prof_active == {1'b0, $past(prof_boot)})
    else $error("boot profile not applied");
  a_frozen_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ##2 1'b1 |-> grab_sync[1] == $past(i_grabbing, 2))
    else $error("frozen flag not following grab");

endmodule : cxpcfg_bank
`default_nettype wire

// ===== tb/cxpcfg_host_model.sv
// host-side register master for the bank's Avalon-MM slave port
// assumes the bench's own timeout ends a hung wait
`timescale 1ns/1ps
`default_nettype none
module cxpcfg_host_model
(
  input  wire logic        i_clk,
  input  wire logic        i_waitrequest,
  input  wire logic [31:0] i_readdata,
  output logic [7:0]       o_address,
  output logic             o_read,
  output logic             o_write,
  output logic [31:0]      o_writedata,
  output logic [3:0]       o_byteenable
);
  initial
  begin
    o_address    = 8'h00;
    o_read       = 1'b0;
    o_write      = 1'b0;
    o_writedata  = 32'h0000_0000;
    o_byteenable = 4'hF;
  end

  // request held until waitrequest is sampled low, data taken there
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clk);
    o_address   <= a;
    o_writedata <= d;
    o_read      <= !w;
    o_write     <= w;
    @(posedge i_clk);
    while (i_waitrequest !== 1'b0)
      @(posedge i_clk);
    q = i_readdata;
    o_read  <= 1'b0;
    o_write <= 1'b0;
  endtask : xfer
endmodule : cxpcfg_host_model
`default_nettype wire

// ===== tb/cxp_link_config_status_bank_bench.sv
// self-checking bench for the link config/status bank
// assumes the host model as bus master; counters cut to 2 bits
`timescale 1ns/1ps
`default_nettype none
module cxp_link_config_status_bank_bench
  import cxpcfg_pkg::*;
;
  typedef struct packed
  {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } cxpcfg_row_t;
  localparam int N_ROWS = 22;
  localparam cxpcfg_row_t ROWS [N_ROWS] = '{
    '{1'b1, OFS_SPEED, 32'h3, 32'h3},
    '{1'b1, OFS_SPEED, 32'h5, 32'h3},
    '{1'b1, OFS_SPEED, 32'h1, 32'h3},
    '{1'b0, OFS_SPEED_MAX, 32'h0, 32'h4},
    '{1'b1, OFS_LANES, 32'h1, 32'h1},
    '{1'b1, OFS_LANES, 32'h2, 32'h1},
    '{1'b0, OFS_LANES_MAX, 32'h0, 32'h1},
    '{1'b1, OFS_PAT_MODE, 32'h1, 32'h1},
    '{1'b1, OFS_PAT_MODE, 32'h2, 32'h2},
    '{1'b1, OFS_PAT_MODE, 32'h3, 32'h3},
    '{1'b1, OFS_PAT_MODE, 32'h0, 32'h0},
    '{1'b1, OFS_PAT_LEVEL, 32'hFFF, 32'hFFF},
    '{1'b1, OFS_PAT_LEVEL, 32'h1000, 32'hFFF},
    '{1'b1, OFS_PROF_SEL, 32'h3, 32'h0},
    '{1'b1, OFS_LANE_SEL, 32'h2, 32'h0},
    '{1'b1, OFS_H_SIZE, 32'h5, 32'hA00},
    '{1'b0, OFS_V_SIZE, 32'h0, 32'h780},
    '{1'b0, OFS_PIX_FMT, 32'h0, 32'h101},
    '{1'b0, OFS_H_OFFSET, 32'h0, 32'h10},
    '{1'b0, OFS_V_OFFSET, 32'h0, 32'h20},
    '{1'b1, OFS_ACQ, 32'h1, 32'h0},
    '{1'b1, 8'h7C, 32'h1, 32'h0}
  };
  localparam logic [7:0] ERR_OFS [3] = '{OFS_KCODE_ERR, OFS_DISP_ERR,
                                         OFS_PROTO_ERR};

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [1:0]  tx = 2'h0;
  logic [2:0]  err = 3'h0;
  logic        streaming = 1'b0;
  logic        grabbing = 1'b0;
  logic [2:0]  speed_act;
  logic        lanes_act;
  logic [1:0]  pat_mode;
  logic [11:0] pat_level;
  logic        save_req;
  logic [1:0]  save_slot;
  logic        restart;
  logic        save_seen = 1'b0;
  logic        restart_seen = 1'b0;
  logic [7:0]  err_code = 8'h11;
  logic [15:0] h_size = 16'h0A00;
  logic [1:0]  seen_slot = 2'h0;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #25 clk = ~clk;

  cxpcfg_host_model host (.i_clk(clk), .i_waitrequest(waitrequest),
    .i_readdata(readdata), .o_address(address), .o_read(read),
    .o_write(write), .o_writedata(writedata), .o_byteenable(byteenable));

  // short counters so saturation is reached in a few events
  cxpcfg_bank #(.CNT_W(2)) dut (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_avs_address(address), .i_avs_read(read), .i_avs_write(write),
    .i_avs_writedata(writedata), .i_avs_byteenable(byteenable),
    .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest),
    .i_test_tx_pulse(tx), .i_kcode_err(err[0]), .i_disp_err(err[1]),
    .i_proto_err(err[2]), .i_proto_err_code(err_code),
    .i_h_size(h_size), .i_h_offset(16'h0010), .i_v_size(16'h0780),
    .i_v_offset(16'h0020), .i_pix_fmt(16'h0101),
    .i_streaming(streaming), .i_grabbing(grabbing),
    .o_speed_active(speed_act), .o_lanes_active(lanes_act),
    .o_pat_mode(pat_mode), .o_pat_level(pat_level),
    .o_save_req(save_req), .o_save_slot(save_slot),
    .o_restart(restart));

  always @(posedge clk)
  begin
    cycles++;
    if (save_req === 1'b1)
    begin
      save_seen = 1'b1;
      seen_slot = save_slot;
    end
    if (restart === 1'b1)
      restart_seen = 1'b1;
    if (cycles == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  // one-cycle event pulse; k 0..2 error kinds, 3..4 test packet lanes
  task automatic ev(input int k);
    @(posedge clk);
    if (k < 3)
      err[k] <= 1'b1;
    else
      tx[k-3] <= 1'b1;
    @(posedge clk);
    err <= 3'h0;
    tx  <= 2'h0;
  endtask : ev

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    chk({29'h0, speed_act}, 32'h2);
    rd(OFS_PROF_ACT, 32'h0);
    foreach (ROWS[i])
    begin
      if (ROWS[i].wr)
        wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, ROWS[i].e);
    end
    chk({20'h0, pat_level}, 32'hFFF);
    h_size <= 16'h0140;
    rd(OFS_H_SIZE, 32'h140);
    wr(OFS_PAT_MODE, 32'h2);
    // output copy lags the setting by one cycle
    repeat (2) @(posedge clk);
    chk({30'h0, pat_mode}, 32'h2);
    // pending grade and lanes must not reach the link yet
    chk({28'h0, lanes_act, speed_act}, 32'h2);
    for (int k = 0; k < 3; k++)
    begin
      ev(k);
      ev(k);
      rd(ERR_OFS[k], 32'h2);
      wr(ERR_OFS[k], 32'h5);
      rd(ERR_OFS[k], 32'h2);
      repeat (3) ev(k);
      rd(ERR_OFS[k], 32'h3);
      wr(ERR_OFS[k], 32'h0);
      rd(ERR_OFS[k], 32'h0);
    end
    err_code <= 8'h5A;
    ev(2);
    // code alone, without an error pulse, must not be taken
    err_code <= 8'hC3;
    rd(OFS_LAST_ERR, 32'h5A);
    wr(OFS_LANE_SEL, 32'h1);
    ev(4);
    ev(4);
    ev(3);
    rd(OFS_TEST_TX, 32'h2);
    wr(OFS_LANE_SEL, 32'h0);
    rd(OFS_TEST_TX, 32'h1);
    wr(OFS_PROF_SAVE, 32'h1);
    // a wrongful save pulse would show one edge after the write
    repeat (2) @(posedge clk);
    chk({31'h0, save_seen}, 32'h0);
    wr(OFS_PROF_SEL, 32'h1);
    wr(OFS_PROF_SAVE, 32'h1);
    repeat (3) @(posedge clk);
    chk({29'h0, save_seen, seen_slot}, 32'h5);
    wr(OFS_SPEED, 32'h4);
    wr(OFS_PAT_LEVEL, 32'h0);
    wr(OFS_PAT_MODE, 32'h1);
    wr(OFS_PROF_LOAD, 32'h1);
    rd(OFS_PAT_MODE, 32'h2);
    rd(OFS_SPEED, 32'h3);
    rd(OFS_PAT_LEVEL, 32'hFFF);
    rd(OFS_PROF_ACT, 32'h1);
    wr(OFS_PROF_BOOT, 32'h1);
    rd(OFS_PROF_BOOT, 32'h1);
    chk({31'h0, restart_seen}, 32'h0);
    wr(OFS_RESTART, 32'h1);
    repeat (4) @(posedge clk);
    chk({31'h0, restart_seen}, 32'h1);
    chk({28'h0, lanes_act, speed_act}, 32'hB);
    rd(OFS_PROF_ACT, 32'h1);
    streaming <= 1'b1;
    grabbing  <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFS_ACQ, 32'h1);
    rd(OFS_FROZEN, 32'h1);
    streaming <= 1'b0;
    grabbing  <= 1'b0;
    repeat (4) @(posedge clk);
    rd(OFS_FROZEN, 32'h0);
    // second reset in mid-run returns to factory boot set
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_PROF_ACT, 32'h0);
    chk({29'h0, speed_act}, 32'h2);
    give_verdict();
  end
endmodule : cxp_link_config_status_bank_bench
`default_nettype wire
